// ---- src/io_map_defs.svh ----
`ifndef IO_MAP_DEFS_SVH
`define IO_MAP_DEFS_SVH
// Functional notes
// - every input, output and parameter is a holding register, read and written as such; writes to input registers are refused with illegal function.
// - register number is the 4xxxx label minus 40000.
// - writes accepted only in Modbus mode with a valid slave identifier.
// - generic parameters grouped by input or output channel number.
// - type specific parameters grouped by that type's instance number.
// - in storage state no radio or I/O activity at all.
// - storage is left only after button one is held five seconds.
// - five second hold of button one enters storage; indicator blinking stops.
// - display may stay lit one minute after entering storage, then off.
// - wake request blocked for one minute after storage entry.
// - display sleeps after fifteen minutes without a button press.
// - display sleep keeps radio and I/O running, only the display blanks.
// - any button press leaves display sleep and restores the display.

// ****************************************************************
// register numbers (4xxxx label minus 40000)
// ****************************************************************
`define REG_DISCRETE_INPUT_ONE      16'h0001
`define REG_DISCRETE_INPUT_FOUR     16'h0004
`define REG_CURRENT_LOOP_INPUT_ONE  16'h0005
`define REG_CURRENT_LOOP_INPUT_THREE 16'h0007
`define REG_TEMPERATURE_READING     16'h0008
`define REG_PULSE_COUNT_HIGH_WORD   16'h0009
`define REG_PULSE_COUNT_LOW_WORD    16'h000a
`define REG_DISCRETE_OUTPUT_ONE     16'h01f5
`define REG_DISCRETE_OUTPUT_TWO     16'h01f6
`define REG_SWITCHED_SUPPLY_THREE   16'h01f9
`define REG_SWITCHED_SUPPLY_FOUR    16'h01fa
`define REG_GENERIC_INPUT_BASE      16'h0400
`define REG_GENERIC_OUTPUT_BASE     16'h0410
`define REG_TYPED_BASE              16'h0500

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define GEN_FIRST_OUTPUT_BIT        10
`define GEN_ENABLE_RESET            16'hffff
`define OUTPUT_RESET                16'h0000
`define TYPED_RESET                 16'h0000
`define SLAVE_ID_MIN                8'h01
`define SLAVE_ID_MAX                8'hf7

// ****************************************************************
// exception codes
// ****************************************************************
`define EXC_NONE                    8'h00
`define EXC_ILLEGAL_FUNCTION        8'h01
`define EXC_ILLEGAL_ADDRESS         8'h02
`define EXC_REFUSED                 8'h04
`define EXC_BUSY                    8'h06

// ****************************************************************
// timing
// ****************************************************************
`define CLK_FREQ_HZ                 64'd100000000
`define HOLD_TIME_MS                64'd5000
`define LOCKOUT_TIME_MS             64'd60000
`define SLEEP_TIME_MS               64'd900000
`define HOLD_CYCLES     (`HOLD_TIME_MS * (`CLK_FREQ_HZ / 64'd1000))
`define LOCKOUT_CYCLES  (`LOCKOUT_TIME_MS * (`CLK_FREQ_HZ / 64'd1000))
`define SLEEP_CYCLES    (`SLEEP_TIME_MS * (`CLK_FREQ_HZ / 64'd1000))
`endif

// ---- src/io_map_pkg.sv ----
package io_map_pkg;

    typedef enum logic {mode_run, mode_storage} node_mode_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] data;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic [7:0]  exc;
    } reg_rsp_t;

    typedef struct packed {
        logic [15:0] current_loop_one;
        logic [15:0] current_loop_three;
        logic [15:0] temperature;
        logic [31:0] pulse_count;
    } front_end_t;

    typedef struct packed {
        logic        display_on;
        logic        radio_enable;
        logic        led_blink_enable;
        logic [1:0]  discrete_output;
        logic [15:0] switched_supply_three;
        logic [15:0] switched_supply_four;
    } node_pins_t;

endpackage

// ---- src/io_register_map_sleep_ctrl.sv ----
`timescale 1ns/1ps
`include "io_map_defs.svh"

module io_register_map_sleep_ctrl #(
    parameter logic [39:0] HOLD_CYCLES    = 40'(`HOLD_CYCLES),
    parameter logic [39:0] LOCKOUT_CYCLES = 40'(`LOCKOUT_CYCLES),
    parameter logic [39:0] SLEEP_CYCLES   = 40'(`SLEEP_CYCLES),
    parameter bit          DISPLAY_LINGER = 1'b1
) (
    input  wire  logic                   ref_clk,
    input  wire  logic                   reset,
    input  wire  logic [3:0]             discrete_input,
    input  wire  logic                   button_one_n,
    input  wire  logic                   button_two_n,
    input  wire  io_map_pkg::front_end_t front_end,
    input  wire  logic                   modbus_mode,
    input  wire  logic [7:0]             slave_id,
    input  wire  io_map_pkg::reg_req_t   req,
    output       io_map_pkg::reg_rsp_t   rsp,
    output       io_map_pkg::node_pins_t pins,
    output       logic                   storage_active
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [1:0][3:0]        di_sync;
        logic [1:0][1:0]        btn_sync;
        logic [1:0]             btn_prev;
        io_map_pkg::node_mode_t mode;
        logic                   display_asleep;
        logic                   hold_fired;
        logic [39:0]            hold_cnt;
        logic [39:0]            lock_cnt;
        logic [39:0]            idle_cnt;
        logic [3:0]             di_snap;
        io_map_pkg::front_end_t fe_snap;
        logic [15:0]            low_latch;
        logic [15:0]            gen_en;
        logic [3:0][15:0]       typed;
        logic [1:0][15:0]       dout;
        logic [1:0][15:0]       supply;
        io_map_pkg::reg_rsp_t   rsp;
        io_map_pkg::node_pins_t pins;
    } state_t;

    state_t q;
    state_t d;

    always_comb begin
        logic        held;
        logic        press;
        logic        lockout;
        logic        run;
        logic        wr_ok;
        logic [15:0] a;
        logic [15:0] rd;
        logic [7:0]  exc;
        logic [3:0]  gi;
        held    = 1'b0;
        press   = 1'b0;
        lockout = 1'b0;
        run     = 1'b0;
        wr_ok   = 1'b0;
        a       = req.addr;
        rd      = 16'h0000;
        exc     = `EXC_NONE;
        gi      = 4'h0;
        d       = q;
        d.rsp   = '0;

        // ****************************************************************
        // pin synchronisers and button edges
        // ****************************************************************
        d.di_sync[0]  = discrete_input;
        d.di_sync[1]  = q.di_sync[0];
        d.btn_sync[0] = {button_two_n, button_one_n};
        d.btn_sync[1] = q.btn_sync[0];
        d.btn_prev    = q.btn_sync[1];
        held  = ~q.btn_sync[1][0];
        press = |(q.btn_prev & ~q.btn_sync[1]);
        lockout = (q.mode == io_map_pkg::mode_storage) && (q.lock_cnt != LOCKOUT_CYCLES);

        // ****************************************************************
        // storage mode by long press of button one
        // ****************************************************************
        if (!held) begin
            d.hold_cnt   = 40'h0;
            d.hold_fired = 1'b0;
        end else if (q.hold_fired || lockout) begin
            d.hold_cnt = 40'h0;
        end else if (q.hold_cnt == HOLD_CYCLES - 40'h1) begin
            d.hold_cnt   = 40'h0;
            d.hold_fired = 1'b1;
            case (q.mode)
                io_map_pkg::mode_run: begin
                    d.mode     = io_map_pkg::mode_storage;
                    d.lock_cnt = 40'h0;
                end
                io_map_pkg::mode_storage: begin
                    d.mode           = io_map_pkg::mode_run;
                    d.idle_cnt       = 40'h0;
                    d.display_asleep = 1'b0;
                end
                default: d.mode = io_map_pkg::mode_run;
            endcase
        end else begin
            d.hold_cnt = q.hold_cnt + 40'h1;
        end

        // ****************************************************************
        // lockout timer and display sleep timer
        // ****************************************************************
        case (q.mode)
            io_map_pkg::mode_storage: begin
                if (lockout) begin
                    d.lock_cnt = q.lock_cnt + 40'h1;
                end
            end
            default: begin
                if (press) begin
                    d.idle_cnt       = 40'h0;
                    d.display_asleep = 1'b0;
                end else if (!q.display_asleep) begin
                    if (q.idle_cnt == SLEEP_CYCLES - 40'h1) begin
                        d.display_asleep = 1'b1;
                    end else begin
                        d.idle_cnt = q.idle_cnt + 40'h1;
                    end
                end
            end
        endcase
        run = (d.mode == io_map_pkg::mode_run);

        // ****************************************************************
        // input sampling, frozen in storage, zero when channel disabled
        // ****************************************************************
        if (q.mode == io_map_pkg::mode_run) begin
            d.di_snap = q.di_sync[1] & q.gen_en[3:0];
            d.fe_snap.current_loop_one   = q.gen_en[4] ? front_end.current_loop_one : 16'h0;
            d.fe_snap.current_loop_three = q.gen_en[6] ? front_end.current_loop_three : 16'h0;
            d.fe_snap.temperature        = q.gen_en[7] ? front_end.temperature : 16'h0;
            d.fe_snap.pulse_count        = q.gen_en[8] ? front_end.pulse_count : 32'h0;
        end

        // ****************************************************************
        // holding register access
        // ****************************************************************
        wr_ok = modbus_mode && (slave_id >= `SLAVE_ID_MIN) && (slave_id <= `SLAVE_ID_MAX);
        if (req.valid) begin
            d.rsp.valid = 1'b1;
            if (q.mode == io_map_pkg::mode_storage) begin
                exc = `EXC_BUSY;
            end else if (a >= `REG_DISCRETE_INPUT_ONE && a <= `REG_DISCRETE_INPUT_FOUR) begin
                rd  = {15'h0, q.di_snap[2'(a - `REG_DISCRETE_INPUT_ONE)]};
                exc = req.write ? `EXC_ILLEGAL_FUNCTION : `EXC_NONE;
            end else if (a == `REG_CURRENT_LOOP_INPUT_ONE) begin
                rd  = q.fe_snap.current_loop_one;
                exc = req.write ? `EXC_ILLEGAL_FUNCTION : `EXC_NONE;
            end else if (a == `REG_CURRENT_LOOP_INPUT_THREE) begin
                rd  = q.fe_snap.current_loop_three;
                exc = req.write ? `EXC_ILLEGAL_FUNCTION : `EXC_NONE;
            end else if (a == `REG_TEMPERATURE_READING) begin
                rd  = q.fe_snap.temperature;
                exc = req.write ? `EXC_ILLEGAL_FUNCTION : `EXC_NONE;
            end else if (a == `REG_PULSE_COUNT_HIGH_WORD) begin
                rd  = q.fe_snap.pulse_count[31:16];
                exc = req.write ? `EXC_ILLEGAL_FUNCTION : `EXC_NONE;
                if (!req.write) begin
                    d.low_latch = q.fe_snap.pulse_count[15:0];
                end
            end else if (a == `REG_PULSE_COUNT_LOW_WORD) begin
                rd  = q.low_latch;
                exc = req.write ? `EXC_ILLEGAL_FUNCTION : `EXC_NONE;
            end else if (a == `REG_DISCRETE_OUTPUT_ONE || a == `REG_DISCRETE_OUTPUT_TWO) begin
                rd = q.dout[a[0] ? 1'b0 : 1'b1];
                if (req.write) begin
                    exc = wr_ok ? `EXC_NONE : `EXC_REFUSED;
                    if (wr_ok) begin
                        d.dout[a[0] ? 1'b0 : 1'b1] = {15'h0, req.data[0]};
                    end
                end
            end else if (a == `REG_SWITCHED_SUPPLY_THREE || a == `REG_SWITCHED_SUPPLY_FOUR) begin
                rd = q.supply[a[0] ? 1'b0 : 1'b1];
                if (req.write) begin
                    exc = wr_ok ? `EXC_NONE : `EXC_REFUSED;
                    if (wr_ok) begin
                        d.supply[a[0] ? 1'b0 : 1'b1] = req.data;
                    end
                end
            end else if (a > `REG_GENERIC_INPUT_BASE && a <= `REG_GENERIC_INPUT_BASE + 16'd10 ||
                         a > `REG_GENERIC_OUTPUT_BASE && a <= `REG_GENERIC_OUTPUT_BASE + 16'd6) begin
                if (a > `REG_GENERIC_OUTPUT_BASE) begin
                    gi = 4'(a - `REG_GENERIC_OUTPUT_BASE - 16'd1 + 16'(`GEN_FIRST_OUTPUT_BIT));
                end else begin
                    gi = 4'(a - `REG_GENERIC_INPUT_BASE - 16'd1);
                end
                rd = {15'h0, q.gen_en[gi]};
                if (req.write) begin
                    exc = wr_ok ? `EXC_NONE : `EXC_REFUSED;
                    if (wr_ok) begin
                        d.gen_en[gi] = req.data[0];
                    end
                end
            end else if (a > `REG_TYPED_BASE && a <= `REG_TYPED_BASE + 16'd4) begin
                rd = q.typed[2'(a - `REG_TYPED_BASE - 16'd1)];
                if (req.write) begin
                    exc = wr_ok ? `EXC_NONE : `EXC_REFUSED;
                    if (wr_ok) begin
                        d.typed[2'(a - `REG_TYPED_BASE - 16'd1)] = req.data;
                    end
                end
            end else begin
                exc = `EXC_ILLEGAL_ADDRESS;
            end
            d.rsp.data = (exc == `EXC_NONE && !req.write) ? rd : 16'h0;
            d.rsp.exc  = exc;
        end

        // ****************************************************************
        // pins: outputs and radio silenced in storage, display per mode
        // ****************************************************************
        d.pins.radio_enable     = run;
        d.pins.led_blink_enable = run;
        d.pins.discrete_output[0] = run && d.gen_en[10] && d.dout[0][0];
        d.pins.discrete_output[1] = run && d.gen_en[11] && d.dout[1][0];
        d.pins.switched_supply_three = (run && d.gen_en[14]) ? d.supply[0] : 16'h0;
        d.pins.switched_supply_four  = (run && d.gen_en[15]) ? d.supply[1] : 16'h0;
        if (run) begin
            d.pins.display_on = !d.display_asleep;
        end else begin
            d.pins.display_on = DISPLAY_LINGER && (d.lock_cnt != LOCKOUT_CYCLES);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            q          <= '0;
            q.btn_sync <= '1;
            q.btn_prev <= '1;
            q.mode     <= io_map_pkg::mode_run;
            q.gen_en   <= `GEN_ENABLE_RESET;
            q.typed    <= {4{`TYPED_RESET}};
            q.dout     <= {2{`OUTPUT_RESET}};
            q.supply   <= {2{`OUTPUT_RESET}};
        end else begin
            q <= d;
        end
    end

    assign rsp            = q.rsp;
    assign pins           = q.pins;
    assign storage_active = (q.mode == io_map_pkg::mode_storage);

endmodule

// ---- test/io_map_checker_assertions.sv ----
`timescale 1ns/1ps
module io_map_checker #(
    parameter logic [39:0] LOCKOUT_CYCLES = 40'h32
) (
    input wire logic                   ref_clk,
    input wire logic                   reset,
    input wire logic                   button_two_n,
    input wire logic                   modbus_mode,
    input wire logic [7:0]             slave_id,
    input wire io_map_pkg::reg_req_t   req,
    input wire io_map_pkg::reg_rsp_t   rsp,
    input wire io_map_pkg::node_pins_t pins,
    input wire logic                   storage_active
);
    logic [39:0] stay_q;
    logic [39:0] stay_d;
    logic        cfg_id;
    logic        wr;
    // ****************************************************************
    // cycles spent in storage
    // ****************************************************************
    always_comb begin
        stay_d = storage_active ? stay_q + 40'h1 : 40'h0;
    end
    always_ff @(posedge ref_clk) begin
        stay_q <= reset ? 40'h0 : stay_d;
    end
    assign cfg_id = modbus_mode && slave_id != 8'h00 && slave_id < 8'hf8;
    assign wr     = req.valid && req.write && !storage_active;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    rsp_timing_a: assert property (req.valid |=> rsp.valid)
        else $error("answer missing one cycle after request");
    rsp_cause_a: assert property (rsp.valid |-> $past(req.valid))
        else $error("answer without request");
    busy_refuse_a: assert property (req.valid && storage_active |=> rsp.exc == 8'h06)
        else $error("request served in storage");
    quiet_store_a: assert property (storage_active && $past(storage_active)
        |-> !pins.radio_enable && !pins.led_blink_enable && pins.discrete_output == 2'b00)
        else $error("activity in storage");
    cfg_refuse_a: assert property (wr && req.addr == 16'h01f5 && !cfg_id
        |=> rsp.exc == 8'h04) else $error("write taken without valid config");
    out_write_a: assert property (wr && req.addr == 16'h01f5 && cfg_id
        |=> rsp.exc == 8'h00 && pins.discrete_output[0] == $past(req.data[0]))
        else $error("output write lost");
    ro_refuse_a: assert property (wr && req.addr == 16'h0001 && cfg_id |=> rsp.exc == 8'h01)
        else $error("input register written");
    unmapped_a: assert property (req.valid && !req.write && req.addr == 16'h0006
        && !storage_active |=> rsp.exc == 8'h02) else $error("unmapped read accepted");
    lockout_a: assert property ($fell(storage_active) |-> stay_q >= LOCKOUT_CYCLES)
        else $error("storage left too early");
    wake_press_a: assert property ($fell(button_two_n) && !storage_active
        |-> ##[1:6] pins.display_on) else $error("press did not restore display");
    cover property (storage_active && req.valid);
    cover property ($fell(pins.display_on) && !storage_active);
    cover property ($fell(storage_active));
endmodule
bind io_register_map_sleep_ctrl io_map_checker #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES))
    i_io_map_checker (.ref_clk(ref_clk), .reset(reset), .button_two_n(button_two_n),
    .modbus_mode(modbus_mode), .slave_id(slave_id), .req(req), .rsp(rsp), .pins(pins),
    .storage_active(storage_active));

// ---- test/modbus_master_model.sv ----
`timescale 1ns/1ps
module modbus_master_model (
    input  wire io_map_pkg::reg_rsp_t rsp,
    input  wire logic                 ref_clk,
    output io_map_pkg::reg_req_t      req,
    output logic                      modbus_mode,
    output logic [7:0]                slave_id
);
    initial begin
        req = '0;
        modbus_mode = 1'b1;
        slave_id = 8'h05;
    end
    task automatic cfg(input logic m, input logic [7:0] id);
        @(posedge ref_clk);
        modbus_mode <= m;
        slave_id <= id;
    endtask
    // one holding-register command; idle fields are scrambled
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                          output io_map_pkg::reg_rsp_t r);
        @(posedge ref_clk);
        req <= '{valid: 1'b1, write: w, addr: a, data: d};
        @(posedge ref_clk);
        req <= '{valid: 1'b0, write: ~w, addr: ~a, data: ~d};
        #1;
        r = rsp;
    endtask
endmodule

// ---- test/io_register_map_sleep_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
end
module io_register_map_sleep_ctrl_tb_top;
    localparam int HOLD = 20;
    localparam int LOCK = 50;
    localparam int SLP  = 100;
    logic                   ref_clk;
    logic                   reset;
    logic                   button_one_n;
    logic                   button_two_n;
    logic [3:0]             discrete_input;
    logic                   modbus_mode;
    logic [7:0]             slave_id;
    logic                   storage_active;
    io_map_pkg::front_end_t front_end;
    io_map_pkg::reg_req_t   req;
    io_map_pkg::reg_rsp_t   rsp;
    io_map_pkg::node_pins_t pins;
    int                     n_mismatch;
    int                     comparisons;
    int                     cycles;
    io_register_map_sleep_ctrl #(.HOLD_CYCLES(40'(HOLD)), .LOCKOUT_CYCLES(40'(LOCK)),
        .SLEEP_CYCLES(40'(SLP)), .DISPLAY_LINGER(1'b1)) i_io_register_map_sleep_ctrl (
        .ref_clk(ref_clk), .reset(reset), .discrete_input(discrete_input),
        .button_one_n(button_one_n), .button_two_n(button_two_n), .front_end(front_end),
        .modbus_mode(modbus_mode), .slave_id(slave_id), .req(req), .rsp(rsp),
        .pins(pins), .storage_active(storage_active));
    modbus_master_model i_modbus_master_model (.rsp(rsp), .ref_clk(ref_clk), .req(req),
        .modbus_mode(modbus_mode), .slave_id(slave_id));
    // ****************************************************************
    // clock, timeout and shared tasks
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic hold(input logic one, input int n);
        @(posedge ref_clk);
        if (one) button_one_n <= 1'b0;
        else button_two_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        button_one_n <= 1'b1;
        button_two_n <= 1'b1;
    endtask
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        input logic [7:0] ex, input logic [15:0] ed);
        io_map_pkg::reg_rsp_t r;
        i_modbus_master_model.access(w, a, d, r);
        `CHK("valid", 1'b1, r.valid)
        `CHK("exc", ex, r.exc)
        `CHK("data", ed, r.data)
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_vals();
        xfer(1'b0, 16'h01f5, 16'h0, 8'h00, 16'h0);
        xfer(1'b0, 16'h01f6, 16'h0, 8'h00, 16'h0);
        xfer(1'b0, 16'h01f9, 16'h0, 8'h00, 16'h0);
        xfer(1'b0, 16'h01fa, 16'h0, 8'h00, 16'h0);
        xfer(1'b0, 16'h0401, 16'h0, 8'h00, 16'h1);
        xfer(1'b0, 16'h0501, 16'h0, 8'h00, 16'h0);
        `CHK("radio", 1'b1, pins.radio_enable)
    endtask
    task automatic t_inputs();
        discrete_input <= 4'b1010;
        front_end <= '{16'h1111, 16'h3333, 16'h8001, 32'habcd1234};
        wait_n(4);
        for (int i = 1; i <= 4; i++) xfer(1'b0, 16'(i), 16'h0, 8'h00, 16'(i % 2 == 0));
        xfer(1'b0, 16'h0005, 16'h0, 8'h00, 16'h1111);
        xfer(1'b0, 16'h0007, 16'h0, 8'h00, 16'h3333);
        xfer(1'b0, 16'h0008, 16'h0, 8'h00, 16'h8001);
        xfer(1'b0, 16'h0009, 16'h0, 8'h00, 16'habcd);
        front_end.pulse_count <= 32'h55556666;
        wait_n(2);
        xfer(1'b0, 16'h000a, 16'h0, 8'h00, 16'h1234);
    endtask
    task automatic t_refuse();
        i_modbus_master_model.cfg(1'b0, 8'h05);
        xfer(1'b1, 16'h01f5, 16'h1, 8'h04, 16'h0);
        i_modbus_master_model.cfg(1'b1, 8'h00);
        xfer(1'b1, 16'h01f5, 16'h1, 8'h04, 16'h0);
        i_modbus_master_model.cfg(1'b1, 8'hf8);
        xfer(1'b1, 16'h01f5, 16'h1, 8'h04, 16'h0);
        i_modbus_master_model.cfg(1'b1, 8'hf7);
        xfer(1'b1, 16'h01f5, 16'h1, 8'h00, 16'h0);
        `CHK("out", 2'b01, pins.discrete_output)
        xfer(1'b1, 16'h01f9, 16'h1234, 8'h00, 16'h0);
        `CHK("sp3", 16'h1234, pins.switched_supply_three)
        xfer(1'b1, 16'h01fa, 16'h5678, 8'h00, 16'h0);
        `CHK("sp4", 16'h5678, pins.switched_supply_four)
        xfer(1'b0, 16'h01f5, 16'h0, 8'h00, 16'h1);
        xfer(1'b1, 16'h0001, 16'h1, 8'h01, 16'h0);
        xfer(1'b0, 16'h0006, 16'h0, 8'h02, 16'h0);
        xfer(1'b0, 16'h01f7, 16'h0, 8'h02, 16'h0);
        xfer(1'b1, 16'h0405, 16'h0, 8'h00, 16'h0);
        xfer(1'b0, 16'h0005, 16'h0, 8'h00, 16'h0);
        xfer(1'b1, 16'h0502, 16'h00ab, 8'h00, 16'h0);
        xfer(1'b0, 16'h0502, 16'h0, 8'h00, 16'h00ab);
    endtask
    task automatic t_storage();
        hold(1'b1, HOLD + 6);
        wait_n(2);
        `CHK("store", 1'b1, storage_active)
        `CHK("blink", 1'b0, pins.led_blink_enable)
        `CHK("radio", 1'b0, pins.radio_enable)
        `CHK("out", 2'b00, pins.discrete_output)
        `CHK("sp3", 16'h0, pins.switched_supply_three)
        `CHK("sp4", 16'h0, pins.switched_supply_four)
        `CHK("disp", 1'b1, pins.display_on)
        xfer(1'b0, 16'h0007, 16'h0, 8'h06, 16'h0);
        hold(1'b1, HOLD + 6);
        wait_n(2);
        `CHK("store", 1'b1, storage_active)
        wait_n(LOCK - 25);
        `CHK("disp", 1'b0, pins.display_on)
        hold(1'b1, HOLD - 6);
        wait_n(4);
        `CHK("store", 1'b1, storage_active)
        hold(1'b1, HOLD + 6);
        wait_n(2);
        `CHK("store", 1'b0, storage_active)
        `CHK("radio", 1'b1, pins.radio_enable)
        `CHK("blink", 1'b1, pins.led_blink_enable)
        `CHK("sp4", 16'h5678, pins.switched_supply_four)
    endtask
    task automatic t_sleep();
        hold(1'b0, 3);
        wait_n(SLP - 15);
        `CHK("disp", 1'b1, pins.display_on)
        wait_n(25);
        `CHK("disp", 1'b0, pins.display_on)
        `CHK("radio", 1'b1, pins.radio_enable)
        xfer(1'b0, 16'h0007, 16'h0, 8'h00, 16'h3333);
        hold(1'b0, 3);
        wait_n(2);
        `CHK("disp", 1'b1, pins.display_on)
    endtask
    initial begin
        reset = 1'b1;
        button_one_n = 1'b1;
        button_two_n = 1'b1;
        discrete_input = 4'h0;
        front_end = '0;
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset_vals();
        t_inputs();
        t_refuse();
        t_storage();
        t_sleep();
        stop_test();
    end
endmodule
